//--- ebbp_board.sv
// Board circuitry on the eight port pins: pull-ups and an optional driver per pin.
// Assumes the device's pin_out/pin_oe; resolves each wire and flags contention.
`timescale 1ns/1ps
`default_nettype none

module ebbp_board
(
  // Device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Board drive
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  // Resolved wire and fault flag
  output logic      [7:0] level,
  output logic            clash
);
  // Released pins the board does not drive float up to the pull-up level
  assign level = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_val) | (~pin_oe & ~drv_en);
  assign clash = |(pin_oe & drv_en);
endmodule

`default_nettype wire

//--- ebbp_map.svh
// Register map, field positions, reset values for the eight-bit port block.
// Assumes a 32-bit APB with byte addresses, one aligned word per register.
`ifndef EBBP_MAP_SVH
`define EBBP_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Offsets
`define EBBP_OFF_PIN_LEVEL 8'h00
`define EBBP_OFF_LATCH     8'h04
`define EBBP_OFF_DIR       8'h08
`define EBBP_OFF_CTRL      8'h0C
`define EBBP_OFF_STATUS    8'h10

////////////////////////////////////////////////////////////////////////////////
// Fields
`define EBBP_CTRL_MODE_BIT 4
`define EBBP_CTRL_ANA_LSB  0
`define EBBP_STAT_ACT_BIT  0
`define EBBP_STAT_BLK_BIT  1
`define EBBP_PWM_A_PIN     4

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define EBBP_RST_LATCH     8'h00
`define EBBP_RST_DIR       8'hFF
`define EBBP_RST_MODE      1'h0
`define EBBP_RST_ANA       4'hF

`endif

//--- ebbp_pin_mux.sv
// Per-pin selection of driver enable and output value.
// Assumes all inputs are on clk; the caller registers the outputs.
`timescale 1ns/1ps
`default_nettype none

module ebbp_pin_mux
  import ebbp_pkg::*;
(
  // Port registers
  input  wire logic      [7:0] dir,
  input  wire logic      [7:0] lat,
  // Slave bus overlay
  input  wire logic            psp_act,
  input  wire ebbp_psp_t       parallel_slave_bus,
  // Peripheral overlay
  input  wire logic      [7:0] chan_en,
  input  wire logic      [7:0] chan_val,
  // Pin drive
  output logic           [7:0] out,
  output logic           [7:0] oe
);

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // Slave bus wins, then direction, then peripheral over latch
      assign oe[i]  = psp_act ? parallel_slave_bus.drive : ~dir[i];
      assign out[i] = psp_act    ? parallel_slave_bus.dout[i] :
                      chan_en[i] ? chan_val[i] : lat[i];
    end
  endgenerate

endmodule

`default_nettype wire

//--- ebbp_pkg.sv
// Types shared by the eight-bit port block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package ebbp_pkg;

  // Output mode of the enhanced capture/PWM unit
  typedef enum logic [1:0] {
    EBBP_PWM_OFF    = 2'h0,
    EBBP_PWM_SINGLE = 2'h1,
    EBBP_PWM_DUAL   = 2'h2,
    EBBP_PWM_QUAD   = 2'h3
  } ebbp_pwm_mode_t;

  typedef enum logic [1:0] {
    EBBP_IDLE = 2'h1,
    EBBP_RESP = 2'h2
  } ebbp_bus_st_t;

  typedef struct packed {
    ebbp_pwm_mode_t mode;
    logic [3:0]     val;
    logic           cmp_en;
    logic           cmp_out;
  } ebbp_pwm_t;

  typedef struct packed {
    logic       drive;
    logic [7:0] dout;
  } ebbp_psp_t;

  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
  } ebbp_sync_st_t;

  typedef struct packed {
    ebbp_bus_st_t bus_st;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [7:0]   lat;
    logic [7:0]   dir;
    logic         mode;
    logic [3:0]   ana;
    logic [7:0]   pin_out;
    logic [7:0]   pin_oe;
    logic         psp_act;
    logic         psp_blk;
    logic [7:0]   psp_din;
    logic         cap_in;
  } ebbp_state_t;

endpackage

`default_nettype wire

//--- ebbp_port_d.sv
// Eight-bit bidirectional port with APB registers and pin overlays.
// Assumes an APB master on clk, pins asynchronous to clk, and the slave
// bus and capture/PWM units running on clk.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "ebbp_map.svh"
`default_nettype none

module ebbp_port_d
  import ebbp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // Pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  // Slave bus unit
  input  wire ebbp_psp_t   psp_i,
  output logic             slave_bus_active,
  output logic      [7:0]  slave_bus_din,
  // Capture/PWM unit
  input  wire ebbp_pwm_t   pwm_i,
  output logic             capture_in
);

  ebbp_state_t st_q;
  ebbp_state_t st_d;
  logic [7:0]  pins_s;
  logic [7:0]  pin_level;
  logic [7:0]  chan_en;
  logic [7:0]  chan_val;
  logic [7:0]  mux_out;
  logic [7:0]  mux_oe;
  logic        pwm_on;
  logic        pwm_multi;
  logic        psp_eff;

  //////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  ebbp_sync u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (pin_in),
    .q     (pins_s)
  );

  assign pin_level = pins_s & ~{4'h0, st_q.ana};

  //////////////////////////////////////////////////////////////////////////////
  // Overlay selection

  assign pwm_on    = (pwm_i.mode != EBBP_PWM_OFF);
  assign pwm_multi = (pwm_i.mode == EBBP_PWM_DUAL) || (pwm_i.mode == EBBP_PWM_QUAD);
  assign psp_eff   = st_q.mode & ~pwm_multi;

  assign chan_en  = {{2{pwm_i.mode == EBBP_PWM_QUAD}}, pwm_multi, pwm_on | pwm_i.cmp_en, 4'h0};
  assign chan_val = {pwm_i.val[3:1], pwm_on ? pwm_i.val[0] : pwm_i.cmp_out, 4'h0};

  ebbp_pin_mux u_mux (
    .dir      (st_q.dir),
    .lat      (st_q.lat),
    .psp_act  (psp_eff),
    .parallel_slave_bus      (psp_i),
    .chan_en  (chan_en),
    .chan_val (chan_val),
    .out      (mux_out),
    .oe       (mux_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_d         = st_q;
    st_d.pin_out = mux_out;
    st_d.pin_oe  = mux_oe;
    st_d.psp_act = psp_eff;
    st_d.psp_blk = st_q.mode & pwm_multi;
    st_d.psp_din = pins_s;
    st_d.cap_in  = pins_s[`EBBP_PWM_A_PIN];
    case (st_q.bus_st)
      EBBP_IDLE: begin
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        if (psel && penable) begin
          st_d.bus_st = EBBP_RESP;
          st_d.pready = 1'b1;
          st_d.prdata = 32'h0000_0000;
          case (paddr)
            `EBBP_OFF_PIN_LEVEL: begin
              st_d.prdata[7:0] = pin_level;
            end
            `EBBP_OFF_LATCH: begin
              st_d.prdata[7:0] = st_q.lat;
            end
            `EBBP_OFF_DIR: begin
              st_d.prdata[7:0] = st_q.dir;
            end
            `EBBP_OFF_CTRL: begin
              st_d.prdata[`EBBP_CTRL_MODE_BIT] = st_q.mode;
              st_d.prdata[`EBBP_CTRL_ANA_LSB +: 4] = st_q.ana;
            end
            `EBBP_OFF_STATUS: begin
              st_d.prdata[`EBBP_STAT_ACT_BIT] = st_q.psp_act;
              st_d.prdata[`EBBP_STAT_BLK_BIT] = st_q.psp_blk;
            end
            default: begin
              st_d.pslverr = 1'b1;
            end
          endcase
        end
      end
      EBBP_RESP: begin
        st_d.bus_st  = EBBP_IDLE;
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
        if (psel && penable && pwrite && !st_q.pslverr) begin
          case (paddr)
            `EBBP_OFF_PIN_LEVEL: begin
              st_d.lat = pwdata[7:0];
            end
            `EBBP_OFF_LATCH: begin
              st_d.lat = pwdata[7:0];
            end
            `EBBP_OFF_DIR: begin
              st_d.dir = pwdata[7:0];
            end
            `EBBP_OFF_CTRL: begin
              st_d.mode = pwdata[`EBBP_CTRL_MODE_BIT];
              st_d.ana  = pwdata[`EBBP_CTRL_ANA_LSB +: 4];
            end
            default: begin
              st_d.lat = st_q.lat;
            end
          endcase
        end
      end
      default: begin
        st_d.bus_st  = EBBP_IDLE;
        st_d.pready  = 1'b0;
        st_d.pslverr = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q         <= '0;
      st_q.bus_st  <= EBBP_IDLE;
      st_q.lat     <= `EBBP_RST_LATCH;
      st_q.dir     <= `EBBP_RST_DIR;
      st_q.mode    <= `EBBP_RST_MODE;
      st_q.ana     <= `EBBP_RST_ANA;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready           = st_q.pready;
  assign pslverr          = st_q.pslverr;
  assign prdata           = st_q.prdata;
  assign pin_out          = st_q.pin_out;
  assign pin_oe           = st_q.pin_oe;
  assign slave_bus_active = st_q.psp_act;
  assign slave_bus_din    = st_q.psp_din;
  assign capture_in       = st_q.cap_in;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_access_start;
    psel && penable && !pready;
  endsequence

  sequence s_read_at(logic [7:0] a);
    psel && penable && !pready && !pwrite && paddr == a;
  endsequence

  sequence s_write_done(logic [7:0] a);
    psel && penable && pready && pwrite && !pslverr && paddr == a;
  endsequence

  sequence s_gpio_mode;
    !psp_eff && pwm_i.mode == EBBP_PWM_OFF && !pwm_i.cmp_en;
  endsequence

  chk_ready_one_wait: assert property (
    s_access_start |=> pready ##1 !pready)
    else $error("APB answer not after exactly one wait cycle");

  chk_input_hiz: assert property (
    s_gpio_mode and st_q.dir == 8'hFF |=> pin_oe == 8'h00)
    else $error("Input pin driver not released");

  chk_output_latch: assert property (
    s_gpio_mode and st_q.dir == 8'h00 |=> pin_oe == 8'hFF && pin_out == $past(st_q.lat))
    else $error("Output pin not driven from latch");

  chk_latch_readback: assert property (
    s_read_at(`EBBP_OFF_LATCH) |=> pready && prdata == {24'h0, $past(st_q.lat)})
    else $error("Latch read did not return latch contents");

  chk_per_pin_dir: assert property (
    s_gpio_mode |=> pin_oe == ~$past(st_q.dir))
    else $error("Pin enable does not follow its own direction bit");

  chk_slave_mode_on: assert property (
    st_q.mode && !pwm_multi |=> slave_bus_active)
    else $error("Mode select did not enable slave bus");

  chk_slave_owns_pins: assert property (
    psp_eff |=> pin_oe == {8{$past(psp_i.drive)}} && pin_out == $past(psp_i.dout))
    else $error("Slave bus does not control the pins");

  chk_analog_zero: assert property (
    s_read_at(`EBBP_OFF_PIN_LEVEL) |=> (prdata[3:0] & $past(st_q.ana)) == 4'h0)
    else $error("Analog-selected pin read nonzero");

  chk_reset_inputs: assert property (
    $past(reset) |-> pin_oe == 8'h00 && st_q.dir == 8'hFF)
    else $error("Pins not inputs after reset");

  chk_pwm_blocks_slave: assert property (
    pwm_multi |=> !slave_bus_active ##0 (!$past(st_q.mode) || st_q.psp_blk))
    else $error("Dual or quad PWM did not disable slave bus");

  chk_pwm_quad_pins: assert property (
    !psp_eff && pwm_i.mode == EBBP_PWM_QUAD && st_q.dir[7:4] == 4'h0
    |=> pin_oe[7:4] == 4'hF && pin_out[7:4] == $past(pwm_i.val))
    else $error("Quad PWM channels not on pins four to seven");

  chk_pin_write_latch: assert property (
    s_write_done(`EBBP_OFF_PIN_LEVEL) |=> st_q.lat == $past(pwdata[7:0]))
    else $error("Pin-level write did not load the latch");

  chk_dir_reset: assert property (
    $past(reset) |-> st_q.dir == `EBBP_RST_DIR ##2 (st_q.dir == 8'hFF || $past(pready, 2)))
    else $error("Direction register not all ones after reset");

  chk_unmapped_err: assert property (
    s_access_start and paddr > `EBBP_OFF_STATUS |=> pready && pslverr && prdata == 32'h0)
    else $error("Unmapped access not refused");

  chk_dir_write_only: assert property (
    st_q.dir != $past(st_q.dir) |-> $past(psel && penable && pready && pwrite && paddr == `EBBP_OFF_DIR))
    else $error("Direction register changed outside its write");

  chk_latch_write_only: assert property (
    st_q.lat != $past(st_q.lat) |-> $past(psel && penable && pready && pwrite && !pslverr &&
      (paddr == `EBBP_OFF_LATCH || paddr == `EBBP_OFF_PIN_LEVEL)))
    else $error("Latch changed outside a latch or pin-level write");

  chk_level_read: assert property (
    s_read_at(`EBBP_OFF_PIN_LEVEL) |=> prdata[31:8] == 24'h0 && prdata[7:4] == $past(pins_s[7:4]))
    else $error("Pin-level read does not return sampled pins");

  chk_ctrl_readback: assert property (
    s_read_at(`EBBP_OFF_CTRL) |=> prdata == {27'h0, $past(st_q.mode), $past(st_q.ana)})
    else $error("Control read does not return mode and analog select");

  chk_status_readback: assert property (
    s_read_at(`EBBP_OFF_STATUS) |=> prdata == {30'h0, $past(st_q.psp_blk), $past(st_q.psp_act)})
    else $error("Status read does not return slave bus state");

  chk_slave_din_raw: assert property (
    slave_bus_din == $past(pins_s))
    else $error("Slave bus input does not follow sampled pins");

  chk_capture_follows: assert property (
    capture_in == $past(pins_s[`EBBP_PWM_A_PIN]))
    else $error("Capture input does not follow pin four");

  chk_pwm_dual_pins: assert property (
    !psp_eff && pwm_i.mode == EBBP_PWM_DUAL && st_q.dir[5:4] == 2'h0 |=> pin_out[5:4] == $past(pwm_i.val[1:0]))
    else $error("Dual PWM channels not on pins four and five");

  chk_compare_pin: assert property (
    !psp_eff && pwm_i.mode == EBBP_PWM_OFF && pwm_i.cmp_en && !st_q.dir[4] |=> pin_out[4] == $past(pwm_i.cmp_out))
    else $error("Compare output not on pin four");

  chk_reset_quiet: assert property (
    $past(reset) |-> !pready && !slave_bus_active && !capture_in && pin_out == 8'h00)
    else $error("Outputs not idle after reset");

endmodule

`default_nettype wire

//--- ebbp_port_d_tb.sv
// Self-checking bench for the eight-bit port: APB master, board model, overlays.
// Assumes the register map header; each APB access waits on pready.
`timescale 1ns/1ps
`include "ebbp_map.svh"
`default_nettype none

module ebbp_port_d_tb
  import ebbp_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic        pslverr;
  logic [31:0] prdata;
  logic [7:0]  pin_out;
  logic [7:0]  pin_oe;
  logic [7:0]  level;
  logic        clash;
  logic [7:0]  drv_en = 8'h00;
  logic [7:0]  drv_val = 8'h00;
  ebbp_psp_t   psp_i = '0;
  ebbp_pwm_t   pwm_i = '0;
  logic        slave_bus_active;
  logic [7:0]  slave_bus_din;
  logic        capture_in;
  int          bad_count = 0;
  int          num_checks = 0;

  always #50 clk = ~clk;

  ebbp_port_d ebbp_port_d_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .pin_in(level), .pin_out(pin_out), .pin_oe(pin_oe), .psp_i(psp_i),
    .slave_bus_active(slave_bus_active), .slave_bus_din(slave_bus_din), .pwm_i(pwm_i),
    .capture_in(capture_in));

  ebbp_board ebbp_board_inst (.pin_out(pin_out), .pin_oe(pin_oe), .drv_en(drv_en),
    .drv_val(drv_val), .level(level), .clash(clash));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, {24'h0, d}, rd, err);
    chk(err, 1'b0);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(err, 1'b0);
    chk(rd, exp);
  endtask

  task automatic settle();
    // Output flop, pin wire, two sync flops and the input register, plus two spare edges
    repeat (6) @(posedge clk);
    chk(clash, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk(`EBBP_OFF_LATCH, 32'h00);
    rd_chk(`EBBP_OFF_DIR, 32'hFF);
    rd_chk(`EBBP_OFF_CTRL, 32'h0F);
    chk(pin_oe, 8'h00);
    chk(slave_bus_active, 1'b0);
  endtask

  task automatic t_dir_latch();
    drv_en  <= 8'hF0;
    drv_val <= 8'hC0;
    wr(`EBBP_OFF_LATCH, 8'hA5);
    wr(`EBBP_OFF_DIR, 8'hF0);
    settle();
    chk(pin_oe, 8'h0F);
    chk(pin_out[3:0], 4'h5);
    rd_chk(`EBBP_OFF_LATCH, 32'hA5);
    rd_chk(`EBBP_OFF_PIN_LEVEL, 32'hC0);
    wr(`EBBP_OFF_CTRL, 8'h00);
    rd_chk(`EBBP_OFF_PIN_LEVEL, 32'hC5);
    wr(`EBBP_OFF_PIN_LEVEL, 8'h3C);
    rd_chk(`EBBP_OFF_LATCH, 32'h3C);
    settle();
    chk(pin_out[3:0], 4'hC);
  endtask

  task automatic pwm_case(input ebbp_pwm_mode_t m, input logic [3:0] v, input logic ce,
                          input logic [3:0] exp);
    pwm_i <= '{mode: m, val: v, cmp_en: ce, cmp_out: ce};
    settle();
    chk(pin_out[7:4], exp);
  endtask

  task automatic t_pwm();
    drv_en <= 8'h00;
    wr(`EBBP_OFF_LATCH, 8'h00);
    wr(`EBBP_OFF_DIR, 8'h0F);
    pwm_case(EBBP_PWM_SINGLE, 4'hF, 1'b0, 4'h1);
    pwm_case(EBBP_PWM_DUAL, 4'hF, 1'b0, 4'h3);
    pwm_case(EBBP_PWM_QUAD, 4'hA, 1'b0, 4'hA);
    pwm_case(EBBP_PWM_OFF, 4'hE, 1'b1, 4'h1);
    chk(pin_oe, 8'hF0);
    wr(`EBBP_OFF_DIR, 8'hFF);
    drv_en  <= 8'hFF;
    drv_val <= 8'h10;
    settle();
    chk(pin_oe, 8'h00);
    chk(capture_in, 1'b1);
  endtask

  task automatic t_slave();
    drv_en <= 8'h00;
    pwm_i  <= '0;
    wr(`EBBP_OFF_CTRL, 8'h10);
    psp_i <= '{drive: 1'b1, dout: 8'h96};
    settle();
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'h96);
    chk(slave_bus_active, 1'b1);
    rd_chk(`EBBP_OFF_STATUS, 32'h01);
    psp_i.drive <= 1'b0;
    drv_en  <= 8'hFF;
    drv_val <= 8'h69;
    settle();
    chk(pin_oe, 8'h00);
    chk(slave_bus_din, 8'h69);
    drv_en <= 8'h00;
    psp_i.drive <= 1'b1;
    pwm_i.mode <= EBBP_PWM_DUAL;
    settle();
    chk(slave_bus_active, 1'b0);
    chk(pin_oe, 8'h00);
    rd_chk(`EBBP_OFF_STATUS, 32'h02);
  endtask

  task automatic t_unmapped();
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 8'h14, 32'h55, rd, err);
    chk(err, 1'b1);
    apb(1'b0, 8'h14, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    rd_chk(`EBBP_OFF_LATCH, 32'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_dir_latch();
    t_pwm();
    t_slave();
    t_unmapped();
    close_out();
  end

  initial begin
    #400000;
    bad_count++;
    close_out();
  end
endmodule

`default_nettype wire

//--- ebbp_sync.sv
// Two-flop synchroniser for the eight pin inputs.
// Assumes asynchronous pin levels; q is safe for logic on clk.
`timescale 1ns/1ps
`default_nettype none

module ebbp_sync
  import ebbp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Data
  input  wire logic [7:0] d,
  output logic      [7:0] q
);

  ebbp_sync_st_t st_q;
  ebbp_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

`default_nettype wire
